/* File: src/sfp_map.vh */
`ifndef SFP_MAP_VH
`define SFP_MAP_VH

// command codes
`define SFP_CMD_PERMIT     8'h06
`define SFP_CMD_REVOKE     8'h04
`define SFP_CMD_STAT_RD    8'h05
`define SFP_CMD_STAT_WR    8'h01
`define SFP_CMD_READ       8'h03
`define SFP_CMD_FAST_READ  8'h0b
`define SFP_CMD_DUAL_READ  8'h3b
`define SFP_CMD_PAGE_PROG  8'h02
`define SFP_CMD_BLK_ERASE  8'hd8
`define SFP_CMD_SEC_ERASE  8'h20
`define SFP_CMD_CHIP_ERA_A 8'hc7
`define SFP_CMD_CHIP_ERA_B 8'h60
`define SFP_CMD_PWR_DOWN   8'hb9
`define SFP_CMD_PWR_UP     8'hab

// status register layout
`define SFP_ST_BUSY        0
`define SFP_ST_PERMIT      1
`define SFP_ST_LEVEL_LO    2
`define SFP_ST_LEVEL_HI    5
`define SFP_ST_SPARE       6
`define SFP_ST_LOCK        7
`define SFP_ST_RST         8'h00
`define SFP_LEVEL_NONE     4'h0

// byte counts after which a sequence is complete, or held while the last header byte before output arrives
`define SFP_NB_STAT_WR     6'h02
`define SFP_NB_ADDR        6'h04
`define SFP_NB_PROG        6'h05
`define SFP_NB_RD_START    6'h03
`define SFP_NB_FRD_START   6'h04

// unmodelled array content
`define SFP_ERASED_BYTE    8'hff

// protect map limits
`define SFP_BLK_TOP        4'hf
`define SFP_BLK_14         4'he
`define SFP_BLK_12         4'hc
`define SFP_BLK_8          4'h8
`define SFP_SEC_LIM_9      8'hfd
`define SFP_SEC_LIM_10     8'hfb
`define SFP_SEC_LIM_11     8'hf7
`define SFP_SEC_LIM_12     8'hef
`define SFP_SEC_LIM_13     8'hdf
`define SFP_SEC_LIM_14     8'hbf

// synchroniser reset: select high, pause high, guard high
`define SFP_PIN_RST        5'h13

`endif

/* File: src/sfp_sync.v */
`timescale 1ns/1ps
module sfp_sync #(
   parameter WIDTH = 5,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   // clock and reset
   input  wire             clk_i,
   input  wire             arst_n_i,
   // asynchronous levels in, synchronised levels out
   input  wire [WIDTH-1:0] d_i,
   output reg  [WIDTH-1:0] q_o
);

   reg [WIDTH-1:0] meta_ff;

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_ff <= RST_VAL;
         q_o     <= RST_VAL;
      end else begin
         meta_ff <= d_i;
         q_o     <= meta_ff;
      end
   end

endmodule

/* File: src/sfp_protect.v */
`timescale 1ns/1ps
`include "sfp_map.vh"
module sfp_protect (
   // protect code and target address
   input  wire [3:0]  level_i,
   input  wire [23:0] addr_i,
   // address falls in the protected region
   output reg         prot_o
);

   wire [3:0] blk;
   wire [7:0] sec;

   assign blk = addr_i[19:16];
   assign sec = addr_i[19:12];

   always @* begin
      case (level_i)
         4'h0:    prot_o = 1'b0;
         4'h1:    prot_o = (blk == `SFP_BLK_TOP);
         4'h2:    prot_o = (blk >= `SFP_BLK_14);
         4'h3:    prot_o = (blk >= `SFP_BLK_12);
         4'h4:    prot_o = (blk >= `SFP_BLK_8);
         4'h5:    prot_o = 1'b1;
         4'h6:    prot_o = 1'b1;
         4'h7:    prot_o = 1'b1;
         4'h8:    prot_o = 1'b0;
         4'h9:    prot_o = (sec <= `SFP_SEC_LIM_9);
         4'ha:    prot_o = (sec <= `SFP_SEC_LIM_10);
         4'hb:    prot_o = (sec <= `SFP_SEC_LIM_11);
         4'hc:    prot_o = (sec <= `SFP_SEC_LIM_12);
         4'hd:    prot_o = (sec <= `SFP_SEC_LIM_13);
         4'he:    prot_o = (sec <= `SFP_SEC_LIM_14);
         default: prot_o = 1'b1;
      endcase
   end

endmodule

/* File: src/sfp_top.v */
`timescale 1ns/1ps
`include "sfp_map.vh"
module sfp_top #(
   parameter [19:0] WRITE_CYC = 20'h00100,
   parameter [19:0] PROG_CYC  = 20'h00400,
   parameter [19:0] SEC_CYC   = 20'h01000,
   parameter [19:0] BLK_CYC   = 20'h02000,
   parameter [19:0] CHIP_CYC  = 20'h04000
) (
   // clock and reset
   input  wire        clk_i,
   input  wire        arst_n_i,
   // serial pins from the host
   input  wire        cs_n_i,
   input  wire        sck_i,
   input  wire        data_in_io0_line_i,
   input  wire        hold_n_i,
   input  wire        wp_n_i,
   // serial pins to the host
   output reg         serial_out_o,
   output reg         serial_out_oe_n_o,
   output reg         data_in_io0_line_o,
   output reg         data_in_io0_line_oe_n_o,
   // state visible to the surrounding chip
   output reg  [7:0]  status_o,
   output reg         op_start_o,
   output reg  [7:0]  op_code_o,
   output reg  [23:0] op_addr_o
);

   //-----------------------------------------------------------
   // pin synchronisation and edge detection
   //-----------------------------------------------------------
   wire [4:0] pins_s;
   wire       cs_n_s;
   wire       sck_s;
   wire       si_s;
   wire       hold_n_s;
   wire       wp_n_s;
   reg        sck_d_ff;
   reg        cs_n_d_ff;

   sfp_sync #(
      .WIDTH   (5),
      .RST_VAL (`SFP_PIN_RST)
   ) u_sync (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .d_i      ({cs_n_i, sck_i, data_in_io0_line_i, hold_n_i, wp_n_i}),
      .q_o      (pins_s)
   );

   assign cs_n_s   = pins_s[4];
   assign sck_s    = pins_s[3];
   assign si_s     = pins_s[2];
   assign hold_n_s = pins_s[1];
   assign wp_n_s   = pins_s[0];

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sck_d_ff  <= 1'b0;
         cs_n_d_ff <= 1'b1;
      end else begin
         sck_d_ff  <= sck_s;
         cs_n_d_ff <= cs_n_s;
      end
   end

   wire sck_rise;
   wire sck_fall;
   wire cs_rise;

   assign sck_rise = sck_s & ~sck_d_ff;
   assign sck_fall = ~sck_s & sck_d_ff;
   assign cs_rise  = cs_n_s & ~cs_n_d_ff;

   //-----------------------------------------------------------
   // pause tracking
   //-----------------------------------------------------------
   // sampling the pause level only while the clock is low covers both the
   // edge-with-clock-low case and the wait for the next low clock
   reg paused_ff;
   reg nxt_paused;

   always @* begin
      if (cs_n_s)
         nxt_paused = 1'b0;
      else if (!sck_s)
         nxt_paused = ~hold_n_s;
      else
         nxt_paused = paused_ff;
   end

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i)
         paused_ff <= 1'b0;
      else
         paused_ff <= nxt_paused;
   end

   //-----------------------------------------------------------
   // receive shifter
   //-----------------------------------------------------------
   reg  [2:0]  bit_idx_ff;
   reg  [5:0]  byte_cnt_ff;
   reg  [6:0]  rx_sr_ff;
   reg  [7:0]  cmd_ff;
   reg  [23:0] addr_ff;
   reg         out_ff;
   reg         dual_ff;
   reg         dp_ff;
   reg         busy_ff;
   wire [7:0]  rx_byte;
   wire        rx_take;
   wire        byte_done;
   wire        out_start;

   assign rx_byte   = {rx_sr_ff, si_s};
   // clock and data are don't-care while paused
   assign rx_take   = sck_rise & ~cs_n_s & ~paused_ff;
   assign byte_done = rx_take & (bit_idx_ff == 3'h7);

   // output phase begins after the last header byte of a read sequence
   assign out_start = byte_done & ~dp_ff & ~out_ff & (
      ((byte_cnt_ff == 6'h00) && (rx_byte == `SFP_CMD_STAT_RD)) ||
      (!busy_ff && (byte_cnt_ff == `SFP_NB_RD_START) &&
       (cmd_ff == `SFP_CMD_READ)) ||
      (!busy_ff && (byte_cnt_ff == `SFP_NB_FRD_START) &&
       ((cmd_ff == `SFP_CMD_FAST_READ) ||
        (cmd_ff == `SFP_CMD_DUAL_READ))));

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         bit_idx_ff  <= 3'h0;
         byte_cnt_ff <= 6'h00;
         rx_sr_ff    <= 7'h00;
         cmd_ff      <= 8'h00;
         addr_ff     <= 24'h000000;
         out_ff      <= 1'b0;
         dual_ff     <= 1'b0;
      end else if (cs_n_s) begin
         // deselect, paused or not, drops any partial sequence
         bit_idx_ff  <= 3'h0;
         byte_cnt_ff <= 6'h00;
         out_ff      <= 1'b0;
         dual_ff     <= 1'b0;
      end else if (rx_take) begin
         bit_idx_ff <= bit_idx_ff + 3'h1;
         rx_sr_ff   <= rx_byte[6:0];
         if (byte_done) begin
            if (byte_cnt_ff != 6'h3f)
               byte_cnt_ff <= byte_cnt_ff + 6'h01;
            case (byte_cnt_ff)
               6'h00:   cmd_ff <= rx_byte;
               6'h01:   addr_ff[23:16] <= rx_byte;
               6'h02:   addr_ff[15:8] <= rx_byte;
               6'h03:   addr_ff[7:0] <= rx_byte;
               default: addr_ff <= addr_ff;
            endcase
            if (out_start) begin
               out_ff  <= 1'b1;
               dual_ff <= (cmd_ff == `SFP_CMD_DUAL_READ);
            end
         end
      end
   end

   //-----------------------------------------------------------
   // status register and protection checks
   //-----------------------------------------------------------
   reg  [3:0]  level_ff;
   reg         lock_ff;
   reg         permit_ff;
   wire [7:0]  status_rd;
   wire        guard_n;
   wire        stat_locked;
   wire        prot_addr;
   wire        prot_blk;

   assign status_rd = {lock_ff, 1'b0, level_ff, permit_ff, busy_ff};
   // the guard pin has no meaning while a dual read is executing
   assign guard_n     = dual_ff ? 1'b1 : wp_n_s;
   assign stat_locked = lock_ff & ~guard_n;

   sfp_protect u_prot_addr (
      .level_i (level_ff),
      .addr_i  (addr_ff),
      .prot_o  (prot_addr)
   );

   // a block is refused if any of its sectors is protected; sector
   // protection always grows from sector 0, so the block base decides
   sfp_protect u_prot_blk (
      .level_i (level_ff),
      .addr_i  ({addr_ff[23:16], 16'h0000}),
      .prot_o  (prot_blk)
   );

   //-----------------------------------------------------------
   // command execution at deselect
   //-----------------------------------------------------------
   reg  [19:0] busy_cnt_ff;
   reg         exec_ok;
   reg  [19:0] exec_cyc;
   wire        exec;
   wire        aligned;
   wire        chip_erase;

   assign aligned    = (bit_idx_ff == 3'h0) && (byte_cnt_ff != 6'h00);
   assign exec       = cs_rise & ~paused_ff & aligned;
   assign chip_erase = (cmd_ff == `SFP_CMD_CHIP_ERA_A) ||
                       (cmd_ff == `SFP_CMD_CHIP_ERA_B);

   // decide whether a write-class command may start and for how long
   always @* begin
      exec_ok  = 1'b0;
      exec_cyc = WRITE_CYC;
      case (cmd_ff)
         `SFP_CMD_STAT_WR: begin
            exec_ok  = permit_ff & ~stat_locked &
                       (byte_cnt_ff >= `SFP_NB_STAT_WR);
            exec_cyc = WRITE_CYC;
         end
         `SFP_CMD_PAGE_PROG: begin
            exec_ok  = permit_ff & ~prot_addr &
                       (byte_cnt_ff >= `SFP_NB_PROG);
            exec_cyc = PROG_CYC;
         end
         `SFP_CMD_SEC_ERASE: begin
            exec_ok  = permit_ff & ~prot_addr &
                       (byte_cnt_ff == `SFP_NB_ADDR);
            exec_cyc = SEC_CYC;
         end
         `SFP_CMD_BLK_ERASE: begin
            exec_ok  = permit_ff & ~prot_blk &
                       (byte_cnt_ff == `SFP_NB_ADDR);
            exec_cyc = BLK_CYC;
         end
         default: begin
            if (chip_erase) begin
               exec_ok  = permit_ff &
                          (level_ff == `SFP_LEVEL_NONE) &
                          (byte_cnt_ff == 6'h01);
               exec_cyc = CHIP_CYC;
            end
         end
      endcase
   end

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         permit_ff   <= 1'b0;
         level_ff    <= 4'h0;
         lock_ff     <= 1'b0;
         busy_ff     <= 1'b0;
         busy_cnt_ff <= 20'h00000;
         dp_ff       <= 1'b0;
         op_start_o  <= 1'b0;
         op_code_o   <= 8'h00;
         op_addr_o   <= 24'h000000;
      end else begin
         op_start_o <= 1'b0;
         // the internal operation runs on regardless of the pause pin
         if (busy_ff) begin
            if (busy_cnt_ff == 20'h00001) begin
               busy_ff   <= 1'b0;
               permit_ff <= 1'b0;
            end
            busy_cnt_ff <= busy_cnt_ff - 20'h00001;
         end
         if (exec) begin
            if (dp_ff) begin
               if (cmd_ff == `SFP_CMD_PWR_UP)
                  dp_ff <= 1'b0;
            end else if (!busy_ff) begin
               case (cmd_ff)
                  `SFP_CMD_PERMIT:   permit_ff <= 1'b1;
                  `SFP_CMD_REVOKE:   permit_ff <= 1'b0;
                  `SFP_CMD_PWR_DOWN: dp_ff <= 1'b1;
                  default: begin
                     if (exec_ok) begin
                        busy_ff     <= 1'b1;
                        busy_cnt_ff <= exec_cyc;
                        op_start_o  <= 1'b1;
                        op_code_o   <= cmd_ff;
                        op_addr_o   <= addr_ff;
                        if (cmd_ff == `SFP_CMD_STAT_WR) begin
                           lock_ff  <= addr_ff[16+`SFP_ST_LOCK];
                           level_ff <= addr_ff[16+`SFP_ST_LEVEL_HI:
                                               16+`SFP_ST_LEVEL_LO];
                        end
                     end
                  end
               endcase
            end
         end
      end
   end

   //-----------------------------------------------------------
   // transmit shifter
   //-----------------------------------------------------------
   reg  [7:0] tx_sr_ff;
   reg  [2:0] tx_cnt_ff;
   reg        so_bit_ff;
   reg        io0_bit_ff;
   wire [7:0] tx_src;
   wire [7:0] tx_byte;
   wire       tx_step;

   // array contents are outside this block; reads return erased data
   assign tx_src  = (cmd_ff == `SFP_CMD_STAT_RD) ? status_rd : `SFP_ERASED_BYTE;
   assign tx_byte = (tx_cnt_ff == 3'h0) ? tx_src : tx_sr_ff;
   assign tx_step = sck_fall & out_ff & ~cs_n_s & ~paused_ff;

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_sr_ff   <= 8'h00;
         tx_cnt_ff  <= 3'h0;
         so_bit_ff  <= 1'b0;
         io0_bit_ff <= 1'b0;
      end else if (!out_ff) begin
         tx_cnt_ff <= 3'h0;
      end else if (tx_step) begin
         so_bit_ff <= tx_byte[7];
         if (dual_ff) begin
            io0_bit_ff <= tx_byte[6];
            tx_sr_ff   <= {tx_byte[5:0], 2'b00};
            tx_cnt_ff  <= tx_cnt_ff + 3'h2;
         end else begin
            tx_sr_ff   <= {tx_byte[6:0], 1'b0};
            tx_cnt_ff  <= tx_cnt_ff + 3'h1;
         end
      end
   end

   //-----------------------------------------------------------
   // registered pin drivers
   //-----------------------------------------------------------
   wire drive_so;

   assign drive_so = out_ff & ~cs_n_s & ~paused_ff;

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         serial_out_o            <= 1'b0;
         serial_out_oe_n_o       <= 1'b1;
         data_in_io0_line_o      <= 1'b0;
         data_in_io0_line_oe_n_o <= 1'b1;
         status_o                <= `SFP_ST_RST;
      end else begin
         serial_out_o            <= so_bit_ff;
         serial_out_oe_n_o       <= ~drive_so;
         data_in_io0_line_o      <= io0_bit_ff;
         data_in_io0_line_oe_n_o <= ~(drive_so & dual_ff);
         status_o                <= status_rd;
      end
   end

endmodule

/* File: test/sfp_top_props.sv */
`timescale 1ns/1ps
module sfp_top_props (
   // clock and reset
   input wire        clk_i,
   input wire        arst_n_i,
   // pins from the host
   input wire        cs_n_i,
   input wire        sck_i,
   input wire        hold_n_i,
   input wire        wp_n_i,
   // device outputs
   input wire        serial_out_oe_n_o,
   input wire        data_in_io0_line_oe_n_o,
   input wire [7:0]  status_o,
   input wire        op_start_o,
   input wire [7:0]  op_code_o,
   input wire [23:0] op_addr_o
);
   // ----------
   // properties
   // ----------
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   AST_SPARE_ZERO: assert property (status_o[6] == 1'b0)
      else $error("spare status bit set");
   AST_START_SETS_BUSY: assert property (op_start_o |=> status_o[0] && !$past(status_o[0]))
      else $error("start without busy rising");
   AST_START_NEEDS_PERMIT: assert property (op_start_o |-> status_o[1])
      else $error("start without write permit");
   AST_WRITE_GUARD: assert property (op_start_o && op_code_o == 8'h01 && status_o[7] |-> wp_n_i)
      else $error("status write taken with guard low");
   AST_STATUS_WRITE_BITS: assert property (op_start_o && op_code_o == 8'h01 |=>
      status_o == {op_addr_o[23], 1'b0, op_addr_o[21:18], 2'b11})
      else $error("status write bits wrong");
   AST_CHIP_ERASE_CLEAR: assert property (op_start_o && (op_code_o == 8'hc7 ||
      op_code_o == 8'h60) |-> status_o[5:2] == 4'h0)
      else $error("chip erase with protect level set");
   AST_DONE_CLEARS_PERMIT: assert property ($fell(status_o[0]) |-> !status_o[1])
      else $error("permit kept after completion");
   AST_DESELECT_FLOATS: assert property (cs_n_i [*5] |-> serial_out_oe_n_o &&
      data_in_io0_line_oe_n_o)
      else $error("output driven while deselected");
   AST_PAUSE_FLOATS: assert property ((!hold_n_i && !sck_i) [*5] |-> serial_out_oe_n_o)
      else $error("output driven while paused");
   AST_START_DESELECTED: assert property (op_start_o |-> cs_n_i && $past(cs_n_i))
      else $error("start while selected");
endmodule

bind sfp_top sfp_top_props sfp_top_props_i (
   .clk_i                  (clk_i),
   .arst_n_i               (arst_n_i),
   .cs_n_i                 (cs_n_i),
   .sck_i                  (sck_i),
   .hold_n_i               (hold_n_i),
   .wp_n_i                 (wp_n_i),
   .serial_out_oe_n_o      (serial_out_oe_n_o),
   .data_in_io0_line_oe_n_o(data_in_io0_line_oe_n_o),
   .status_o               (status_o),
   .op_start_o             (op_start_o),
   .op_code_o              (op_code_o),
   .op_addr_o              (op_addr_o)
);

/* File: test/sfp_host.sv */
`timescale 1ns/1ps
module sfp_host (
   // clock
   input  wire clk_i,
   // pins toward the device
   output reg  cs_n_o,
   output reg  sck_o,
   output reg  si_o,
   output reg  si_en_o,
   output reg  hold_n_o,
   output reg  wp_n_o,
   // resolved data lines
   input  wire so_i,
   input  wire io0_i
);
   // ---------------
   // pin sequencing
   // ---------------
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      si_o = 1'b0;
      si_en_o = 1'b1;
      hold_n_o = 1'b1;
      wp_n_o = 1'b1;
   end

   task tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // select only with pause released, so no stale pause is picked up
   task sel;
      tick(1);
      cs_n_o = 1'b0;
      tick(3);
   endtask

   task desel;
      tick(2);
      cs_n_o = 1'b1;
      si_en_o = 1'b1;
      tick(8);
   endtask

   // mode 0: bit set while sck low, taken on the rise, read just before it
   task bits(input int n, input logic [7:0] tx, input bit dual, output logic [7:0] rx);
      rx = 8'h00;
      if (dual)
         si_en_o = 1'b0;
      for (int i = 0; i < n; i++) begin
         si_o = tx[7-i];
         tick(4);
         rx = dual ? {rx[5:0], so_i, io0_i} : {rx[6:0], so_i};
         sck_o = 1'b1;
         tick(4);
         sck_o = 1'b0;
      end
   endtask

   // pause pin only moves while sck is low
   task pins(input bit hold, input bit wp);
      hold_n_o = hold;
      wp_n_o = wp;
      tick(6);
   endtask
endmodule

/* File: test/sfp_top_tb_top.sv */
`timescale 1ns/1ps
module sfp_top_tb_top;
   // -------------------
   // clock, reset, wires
   // -------------------
   logic        clk_i    = 1'b0;
   logic        arst_n_i = 1'b0;
   wire         cs_n, sck, si, si_en, hold_n, wp_n;
   wire         so, so_oe_n, io0, io0_oe_n, op_start;
   wire  [7:0]  status, op_code;
   wire  [23:0] op_addr;
   // a released line shows the inverse of its last value
   wire         so_w  = so ^ so_oe_n;
   wire         io0_w = !io0_oe_n ? io0 : (si_en ? si : ~si);
   int          n_fail = 0;
   int          num_checks = 0;
   int          n_ops = 0;
   int          n0;
   logic [7:0]  rx;
   // {start expected, level byte, erase address}
   logic [32:0] prot_tab [26] = '{33'h1_00_000000, 33'h0_04_0f0000, 33'h1_04_0ef000,
      33'h0_08_0e0000, 33'h1_08_0df000, 33'h0_0c_0c0000, 33'h1_0c_0bf000, 33'h0_10_080000,
      33'h1_10_07f000, 33'h0_14_000000, 33'h0_18_000000, 33'h0_1c_07f000, 33'h1_20_000000,
      33'h0_24_0fd000, 33'h1_24_0fe000, 33'h0_28_0fb000, 33'h1_28_0fc000, 33'h0_2c_0f7000,
      33'h1_2c_0f8000, 33'h0_30_0ef000, 33'h1_30_0f0000, 33'h0_34_0df000, 33'h1_34_0e0000,
      33'h0_38_0bf000, 33'h1_38_0c0000, 33'h0_3c_0ff000};

   always #20 clk_i = ~clk_i;
   always @(posedge clk_i) if (op_start === 1'b1) n_ops <= n_ops + 1;

   sfp_top #(.WRITE_CYC(20'h00010), .PROG_CYC(20'h00010), .SEC_CYC(20'h00010),
      .BLK_CYC(20'h00010), .CHIP_CYC(20'h00200)) sfp_top_i (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .cs_n_i(cs_n), .sck_i(sck),
      .data_in_io0_line_i(io0_w), .hold_n_i(hold_n), .wp_n_i(wp_n),
      .serial_out_o(so), .serial_out_oe_n_o(so_oe_n), .data_in_io0_line_o(io0),
      .data_in_io0_line_oe_n_o(io0_oe_n), .status_o(status), .op_start_o(op_start),
      .op_code_o(op_code), .op_addr_o(op_addr));
   sfp_host sfp_host_i (.clk_i(clk_i), .cs_n_o(cs_n), .sck_o(sck), .si_o(si),
      .si_en_o(si_en), .hold_n_o(hold_n), .wp_n_o(wp_n), .so_i(so_w), .io0_i(io0_w));

   // -----
   // tasks
   // -----
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic b8(input logic [7:0] tx);
      sfp_host_i.bits(8, tx, 1'b0, rx);
   endtask

   task automatic frame(input int nb, input logic [31:0] v);
      sfp_host_i.sel();
      for (int b = nb - 1; b >= 0; b--)
         b8(v[8*b +: 8]);
      sfp_host_i.desel();
   endtask

   task automatic idle;
      for (int i = 0; i < 2000 && status[0] !== 1'b0; i++)
         @(posedge clk_i);
      #1;
      chk("busy", 0, status[0]);
   endtask

   task automatic st(input logic [7:0] exp);
      frame(2, 32'h0500);
      chk("status read", exp, rx);
      chk("status_o", exp, status);
   endtask

   task automatic wsr(input logic [7:0] v);
      frame(1, 32'h06);
      frame(2, {16'h0, 8'h01, v});
      idle();
   endtask

   task tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      #3_000_000;
      n_fail++;
      tally_and_finish();
   end

   // ---------
   // sequences
   // ---------
   initial begin
      repeat (2) @(posedge clk_i);
      #1;
      arst_n_i = 1'b1;
      st(8'h00);
      frame(1, 32'h06);
      st(8'h02);
      frame(1, 32'h04);
      st(8'h00);
      frame(2, 32'h01fc);
      st(8'h00);
      chk("op starts", 0, n_ops);
      frame(1, 32'h06);
      frame(2, 32'h01ff);
      chk("status_o busy", 8'hbf, status);
      idle();
      st(8'hbc);
      sfp_host_i.pins(1'b1, 1'b0);
      frame(1, 32'h06);
      frame(2, 32'h0100);
      st(8'hbe);
      sfp_host_i.pins(1'b1, 1'b1);
      frame(2, 32'h0100);
      idle();
      st(8'h00);
      $display("status write test done");
      frame(1, 32'h06);
      sfp_host_i.sel();
      b8(8'h01);
      b8(8'h3c);
      sfp_host_i.bits(3, 8'h00, 1'b0, rx);
      sfp_host_i.desel();
      st(8'h02);
      wsr(8'h04);
      frame(1, 32'h06);
      frame(1, 32'hc7);
      st(8'h06);
      wsr(8'h00);
      frame(1, 32'h06);
      frame(1, 32'h60);
      frame(1, 32'hc7);
      chk("op code", 8'h60, op_code);
      idle();
      st(8'h00);
      $display("guard and erase test done");
      for (int i = 0; i < 26; i++) begin
         wsr(prot_tab[i][31:24]);
         frame(1, 32'h06);
         n0 = n_ops;
         frame(4, {8'h20, prot_tab[i][23:0]});
         chk("erase start", prot_tab[i][32], n_ops - n0);
         if (prot_tab[i][32])
            chk("erase addr", prot_tab[i][23:0], op_addr);
         idle();
      end
      wsr(8'h00);
      $display("protect map test done");
      frame(1, 32'hb9);
      frame(1, 32'h06);
      frame(1, 32'hab);
      st(8'h00);
      sfp_host_i.pins(1'b1, 1'b0);
      sfp_host_i.sel();
      for (int b = 0; b < 5; b++)
         b8(b == 0 ? 8'h03 : 8'h00);
      chk("single read", 8'hff, rx);
      chk("io0 oe_n", 1, io0_oe_n);
      sfp_host_i.desel();
      sfp_host_i.sel();
      for (int b = 0; b < 5; b++)
         b8(b == 0 ? 8'h3b : {7'h0, b == 4});
      for (int b = 0; b < 2; b++) begin
         sfp_host_i.bits(4, 8'h00, 1'b1, rx);
         chk("dual read", 8'hff, rx);
      end
      chk("io0 oe_n", 0, io0_oe_n);
      sfp_host_i.desel();
      sfp_host_i.pins(1'b1, 1'b1);
      $display("read test done");
      frame(1, 32'h06);
      sfp_host_i.sel();
      b8(8'h05);
      sfp_host_i.pins(1'b0, 1'b1);
      chk("so oe_n paused", 1, so_oe_n);
      sfp_host_i.bits(3, 8'hff, 1'b0, rx);
      sfp_host_i.pins(1'b1, 1'b1);
      b8(8'h00);
      sfp_host_i.desel();
      chk("read after pause", 8'h02, rx);
      sfp_host_i.sel();
      b8(8'h04);
      sfp_host_i.pins(1'b0, 1'b1);
      sfp_host_i.desel();
      sfp_host_i.pins(1'b1, 1'b1);
      st(8'h02);
      // reset in mid-run must drop the write permit
      arst_n_i = 1'b0;
      sfp_host_i.tick(2);
      arst_n_i = 1'b1;
      st(8'h00);
      $display("pause test done");
      tally_and_finish();
   end
endmodule
